// ==== bench/ivd_decoder_assertions.sv ====
// assertion checker for the invalidation decoder
`timescale 1ns/1ps
module ivd_decoder_chk #(
	parameter DOMAIN_W = 16, // domain width
	parameter ADDR_W = 48 // address width
) (
	input wire ref_clk, // clock
	input wire srst, // reset
	input wire cmd_valid, // offered
	input wire [127:0] cmd_word, // command
	input wire cmd_ready, // taken
	input wire cmd_unknown, // bad type
	input wire write_buffer_flush_needed, // flush first
	input wire wbf_req_ff, // flush request
	input wire ctx_valid_ff, // ctx request
	input wire [15:0] ctx_domain_ff, // ctx domain
	input wire [15:0] ctx_requester_ff, // ctx requester
	input wire tlb_valid_ff, // tlb request
	input wire [15:0] tlb_domain_ff, // tlb domain
	input wire [63:0] tlb_addr_ff, // tlb page
	input wire tlb_dir_flush_ff, // dir flush
	input wire tlb_ack, // tlb done
	input wire read_drain_ff, // read drain
	input wire write_drain_ff, // write drain
	input wire [5:0] ep_size_ff, // ep size
	input wire ep_valid_ff, // ep request
	input wire [5:0] ep_outstanding, // ep count
	input wire busy // active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	reg [127:0] w_ff;
	wire take = cmd_valid && cmd_ready;
	wire [3:0] ty = cmd_word[3:0];
	wire [15:0] dmask = ~(~16'h0 << DOMAIN_W);
	wire [63:0] amask = ~(~64'h0 << ADDR_W) & (~64'h0 << 12);
	// previous command word
	always @(posedge ref_clk) begin
		w_ff <= cmd_word;
	end
	chk_wbf_first: assert property (take && write_buffer_flush_needed && (ty == 4'h1 || ty == 4'h2)
		|=> wbf_req_ff && !ctx_valid_ff && !tlb_valid_ff) else $error("flush late");
	chk_ctx_target: assert property (take && !write_buffer_flush_needed && ty == 4'h1 &&
		cmd_word[5:4] == 2'h3 |=> ctx_valid_ff && ctx_domain_ff == w_ff[31:16] &&
		ctx_requester_ff == w_ff[47:32]) else $error("ctx target");
	chk_tlb_domain: assert property (take && ty == 4'h2 |=> tlb_domain_ff ==
		(w_ff[5:4] > 2'h1 ? w_ff[31:16] & dmask : 16'h0)) else $error("tlb dom");
	chk_dir_flush: assert property (take && ty == 4'h2 |=>
		tlb_dir_flush_ff == !(w_ff[5:4] == 2'h3 && w_ff[70])) else $error("dir flush");
	chk_page_addr: assert property (take && ty == 4'h2 && cmd_word[5:4] == 2'h3 |=>
		tlb_addr_ff == (w_ff[127:64] & amask)) else $error("page addr");
	chk_drain_set: assert property (take && ty == 4'h2 |=> (read_drain_ff || !w_ff[7]) &&
		(write_drain_ff || !w_ff[6])) else $error("drain");
	chk_ep_page: assert property (take && ty == 4'h3 && !cmd_word[64] |=>
		ep_size_ff == 6'h0c) else $error("ep page");
	chk_ep_cap: assert property (ep_outstanding <= 6'h20) else $error("ep cap");
	chk_unknown_type: assert property (take && (ty == 4'h0 || ty > 4'h3) |=>
		cmd_unknown) else $error("unknown");
	chk_one_cmd: assert property (take && ty != 4'h0 && ty < 4'h4 |=> busy && !cmd_ready)
		else $error("ready busy");
	chk_ep_room: assert property (ep_valid_ff |-> ep_outstanding < 6'h20) else $error("ep room");
	chk_tlb_hold: assert property (tlb_valid_ff && !tlb_ack |=> tlb_valid_ff)
		else $error("tlb drop");
	cover property (take && ty == 4'h1 && write_buffer_flush_needed);
	cover property (take && ty == 4'h3 && cmd_word[64]);
	cover property (ep_outstanding == 6'h20);
endmodule // ivd_decoder_chk
bind ivd_decoder ivd_decoder_chk #(.DOMAIN_W(DOMAIN_W), .ADDR_W(ADDR_W)) i_ivd_decoder_chk (.*);

// ==== bench/ivd_decoder_tb_top.sv ====
// self-checking bench for the invalidation decoder
`timescale 1ns/1ps
module ivd_decoder_tb_top;
	reg ref_clk = 1'b0;
	reg srst = 1'b1;
	reg cmd_valid = 1'b0;
	reg [127:0] cmd_word = 128'h0;
	reg write_buffer_flush_needed = 1'b0;
	reg throttle_en = 1'b0;
	reg slow = 1'b0;
	reg hold_done = 1'b0;
	wire cmd_ready, cmd_unknown, wbf_req_ff, wbf_done, ctx_valid_ff, ctx_ack, tlb_valid_ff;
	wire tlb_ack, tlb_dir_flush_ff, read_drain_ff, read_drain_done, write_drain_ff;
	wire write_drain_done, ep_valid_ff, ep_ack, ep_done, busy;
	wire [1:0] ctx_level_ff, ctx_fmask_ff, tlb_level_ff;
	wire [15:0] ctx_domain_ff, ctx_requester_ff, tlb_domain_ff, ep_requester_ff;
	wire [63:0] tlb_addr_ff, ep_base_ff;
	wire [5:0] tlb_pmask_ff, ep_size_ff, ep_outstanding;
	integer num_errors = 0;
	integer compares = 0;
	integer i;
	integer l;
	integer h;
	ivd_decoder #(.DOMAIN_W(8), .ADDR_W(48)) i_ivd_decoder (.*);
	ivd_far_model i_ivd_far_model (.*);
	// clock
	always #50 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////
	function [127:0] ctx_w(input [1:0] lv);
		ctx_w = {64'h0, 14'h0, 2'h2, 16'h1234, 16'hA5C3, 10'h0, lv, 4'h1};
	endfunction
	function [127:0] tlb_w(input [1:0] lv, input hi);
		tlb_w = {52'hA_BCD1_2345_6789, 5'h0, hi, 6'h05, 32'h0, 16'hBEEF, 8'h0, hi, !hi, lv, 4'h2};
	endfunction
	function [127:0] ep_w(input [63:0] a, input [4:0] hint);
		ep_w = {a, 16'h0, 16'h4321, 11'h0, hint, 12'h0, 4'h3};
	endfunction
	task chk(input ok, input [8*10-1:0] msg);
		compares = compares + 1;
		if (!ok) begin
			num_errors = num_errors + 1;
			$display("ERROR at %0t: %0s", $time, msg);
		end
	endtask
	task summarize;
		if (num_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task idle;
		integer n;
		n = 0;
		@(posedge ref_clk);
		#1;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge ref_clk);
			#1;
			n = n + 1;
		end
		if (n == 300) begin
			chk(1'b0, "hang");
		end
	endtask
	task send(input [127:0] w);
		idle;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_word <= w;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
	endtask
	task t_ctx;
		@(posedge ref_clk);
		slow <= 1'b1;
		for (l = 0; l < 4; l = l + 1) begin
			// device flush goes straight to the cache
			write_buffer_flush_needed <= (l != 3);
			send(ctx_w(l[1:0]));
			idle;
			chk(ctx_level_ff === (l == 0 ? 2'h1 : l[1:0]), "ctx lvl");
			chk(ctx_fmask_ff === (l == 3 ? 2'h2 : 2'h0), "ctx mask");
			chk(ctx_domain_ff === (l > 1 ? 16'hA5C3 : 16'h0), "ctx dom");
			chk(ctx_requester_ff === (l == 3 ? 16'h1234 : 16'h0), "ctx req");
			// translation flush after each context flush
			send(tlb_w(2'h1, 1'b0));
		end
	endtask
	task t_tlb;
		@(posedge ref_clk);
		write_buffer_flush_needed <= 1'b0;
		slow <= 1'b0;
		for (l = 0; l < 4; l = l + 1) begin
			for (h = 0; h < 2; h = h + 1) begin
				send(tlb_w(l[1:0], h[0]));
				idle;
				chk(tlb_domain_ff === (l > 1 ? 16'h00EF : 16'h0), "tlb dom");
				chk(tlb_level_ff === (l == 0 ? 2'h1 : l[1:0]), "tlb lvl");
				chk(tlb_addr_ff === (l == 3 ? 64'h0000_1234_5678_9000 : 64'h0), "tlb addr");
				chk(tlb_dir_flush_ff === !(l == 3 && h == 1), "tlb dir");
				if (l == 3) begin
					chk(tlb_pmask_ff === 6'h05 && tlb_level_ff === 2'h3, "tlb mask");
				end
			end
		end
	endtask
	task t_ep_one(input [63:0] a, input [5:0] sz, input [63:0] base);
		send(ep_w(a, 5'h0));
		idle;
		chk(ep_size_ff === sz && ep_base_ff === base, "ep range");
		chk(ep_requester_ff === 16'h4321, "ep req");
	endtask
	task t_throttle(input [4:0] hint, input [5:0] lim);
		@(posedge ref_clk);
		throttle_en <= 1'b1;
		hold_done <= 1'b1;
		for (i = 0; i <= lim; i = i + 1) begin
			send(ep_w(64'h0000_0000_0001_0000, hint));
			if (i < lim) begin
				idle;
			end
		end
		repeat (20) @(posedge ref_clk);
		#1;
		chk(busy === 1'b1 && ep_outstanding === lim, "no stall");
		@(posedge ref_clk);
		hold_done <= 1'b0;
		idle;
		repeat (60) @(posedge ref_clk);
		#1;
		chk(ep_outstanding === 6'h0, "no drain");
		@(posedge ref_clk);
		throttle_en <= 1'b0;
	endtask
	task t_unknown(input [3:0] ty);
		send({124'h0, ty});
		#1;
		chk(cmd_unknown === 1'b1, "no flag");
		@(posedge ref_clk);
		#1;
		chk(cmd_unknown === 1'b0 && busy === 1'b0, "stuck");
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk(cmd_ready === 1'b1 && busy === 1'b0 && ep_outstanding === 6'h0, "reset");
		t_ctx;
		t_tlb;
		// translation flush ahead of endpoint flushes
		send(tlb_w(2'h2, 1'b0));
		t_ep_one(64'h0000_0012_3456_7ABC, 6'h0c, 64'h0000_0012_3456_7000);
		t_ep_one(64'h0000_0012_3456_6001, 6'h0d, 64'h0000_0012_3456_6000);
		t_ep_one(64'h0000_0012_3456_5001, 6'h0e, 64'h0000_0012_3456_4000);
		t_throttle(5'h2, 6'h02);
		t_throttle(5'h0, 6'h20);
		t_unknown(4'h4);
		t_unknown(4'hF);
		summarize;
	end
	// watchdog
	initial begin
		#3000000;
		num_errors = num_errors + 1;
		summarize;
	end
endmodule // ivd_decoder_tb_top

// ==== bench/ivd_far_model.sv ====
// far side model: caches, drains and endpoints
`timescale 1ns/1ps
module ivd_far_model (
	input wire ref_clk, // clock
	input wire srst, // reset
	input wire slow, // late answers
	input wire hold_done, // withhold completions
	input wire wbf_req_ff, // flush request
	input wire ctx_valid_ff, // ctx request
	input wire tlb_valid_ff, // tlb request
	input wire ep_valid_ff, // ep request
	input wire read_drain_ff, // read drain
	input wire write_drain_ff, // write drain
	output reg wbf_done, // flush done
	output reg ctx_ack, // ctx done
	output reg tlb_ack, // tlb done
	output reg ep_ack, // ep sent
	output reg ep_done, // ep completion
	output reg read_drain_done, // reads drained
	output reg write_drain_done // writes drained
);
	reg [1:0] cnt_ff;
	reg [5:0] pend_ff;
	wire req = wbf_req_ff | ctx_valid_ff | tlb_valid_ff | ep_valid_ff;
	wire acked = wbf_done | ctx_ack | tlb_ack | ep_ack;
	wire go = req & !acked & (cnt_ff == (slow ? 2'h3 : 2'h0));
	wire fin = (pend_ff != 6'h0) & !hold_done;
	// answer one request at a time, after a short or long wait
	always @(posedge ref_clk) begin
		wbf_done <= go & wbf_req_ff;
		ctx_ack <= go & ctx_valid_ff;
		tlb_ack <= go & tlb_valid_ff;
		ep_ack <= go & ep_valid_ff;
		ep_done <= fin & !srst;
		read_drain_done <= read_drain_ff & !read_drain_done;
		write_drain_done <= write_drain_ff & !write_drain_done;
		cnt_ff <= (srst | go | acked | !req) ? 2'h0 : cnt_ff + 2'h1;
		pend_ff <= srst ? 6'h0 : pend_ff + {5'h0, go & ep_valid_ff} - {5'h0, fin};
	end
endmodule // ivd_far_model

// ==== logic/ivd_consts.vh ====
// constants for the invalidation command decoder
`ifndef IVD_CONSTS_VH
`define IVD_CONSTS_VH

// command word width and type field
`define IVD_CMD_W 128
`define IVD_TYPE_HI 3
`define IVD_TYPE_LO 0

// type codes
`define IVD_TYPE_CTX 4'h1
`define IVD_TYPE_TLB 4'h2
`define IVD_TYPE_EP 4'h3

// shared field positions
`define IVD_LVL_HI 5
`define IVD_LVL_LO 4
`define IVD_DOM_HI 31
`define IVD_DOM_LO 16
`define IVD_REQ_HI 47
`define IVD_REQ_LO 32

// context flush fields
`define IVD_FMASK_HI 49
`define IVD_FMASK_LO 48

// translation flush fields
`define IVD_WFLUSH_BIT 6
`define IVD_RFLUSH_BIT 7
`define IVD_PMASK_HI 69
`define IVD_PMASK_LO 64
`define IVD_HINT_BIT 70
`define IVD_ADDR_HI 127
`define IVD_ADDR_LO 64

// endpoint flush fields
`define IVD_OLIM_HI 20
`define IVD_OLIM_LO 16
`define IVD_RANGE_BIT 64

// context level codes
`define IVD_CLVL_GLOBAL 2'h1
`define IVD_CLVL_DOMAIN 2'h2
`define IVD_CLVL_DEVICE 2'h3

// translation level codes
`define IVD_TLVL_GLOBAL 2'h1
`define IVD_TLVL_DOMAIN 2'h2
`define IVD_TLVL_PAGE 2'h3

// endpoint outstanding ceiling, page size log2 and page address mask
`define IVD_EP_MAX_OUT 6'h20
`define IVD_PAGE_LOG2 6'h0c
`define IVD_PAGE_MASK 64'hffff_ffff_ffff_f000

`endif

// ==== logic/ivd_decoder.v ====
// queued invalidation command decoder and dispatcher
// Functional notes
// - commands are 128 bits; type in bits 3:0; reserved fields zero by software
// - context level decoded like context granularity code; broader flush allowed
// - domain and device context flushes target domain_tag
// - device context flush targets requester_tag
// - function_bits_mask marks requester_tag bits as don't-care
// - write buffer flushed before context flush when needed
// - translation level is global, domain or page; broader allowed
// - read drain finished before next wait when read_flush_flag set
// - write drain finished before next wait when write_flush_flag set
// - domain_tag bits 31:(16+N) ignored; whole field for global
// - keep_upper_hint used only for page flushes
// - page flush with hint clear also flushes directory entries
// - start page from address; bits 127:(64+N) ignored; unused otherwise
// - page_count_mask gives contiguous page count
// - write buffer flushed before translation flush when needed
// - endpoint flush goes to endpoint with requester_tag
// - range_flag clear means one page at address 63:12
// - range_flag set; lowest zero address bit sets range size
// - limit hint of zero means 32 outstanding
// - outstanding requests may be throttled by limit hint
`timescale 1ns/1ps
`include "ivd_consts.vh"
module ivd_decoder #(
	parameter DOMAIN_W = 16, // domain identifier width
	parameter ADDR_W = 48 // guest address width
) (
	input wire ref_clk, // clock
	input wire srst, // sync reset, high
	input wire cmd_valid, // command word offered
	input wire [127:0] cmd_word, // command word
	output wire cmd_ready, // command taken
	output wire cmd_unknown, // pulse, type not handled
	input wire write_buffer_flush_needed, // flush write buffer first
	input wire throttle_en, // limit endpoint traffic
	output reg wbf_req_ff, // write buffer flush request
	input wire wbf_done, // write buffer flush finished
	output reg ctx_valid_ff, // context flush request
	output reg [1:0] ctx_level_ff, // context level code
	output reg [15:0] ctx_domain_ff, // context domain_tag
	output reg [15:0] ctx_requester_ff, // context requester_tag
	output reg [1:0] ctx_fmask_ff, // context function_bits_mask
	input wire ctx_ack, // context cache done
	output reg tlb_valid_ff, // translation flush request
	output reg [1:0] tlb_level_ff, // translation level code
	output reg [15:0] tlb_domain_ff, // masked domain_tag
	output reg [63:0] tlb_addr_ff, // start page address
	output reg [5:0] tlb_pmask_ff, // page_count_mask
	output reg tlb_dir_flush_ff, // also flush directory entries
	input wire tlb_ack, // translation cache done
	output reg read_drain_ff, // read drain pending
	input wire read_drain_done, // read drain finished
	output reg write_drain_ff, // write drain pending
	input wire write_drain_done, // write drain finished
	output reg ep_valid_ff, // endpoint flush request
	output reg [15:0] ep_requester_ff, // endpoint requester_tag
	output reg [63:0] ep_base_ff, // endpoint range base
	output reg [5:0] ep_size_ff, // log2 of range bytes
	input wire ep_ack, // endpoint request sent
	input wire ep_done, // endpoint completion seen
	output wire [5:0] ep_outstanding, // outstanding endpoint count
	output wire busy // command in progress
);
	////////////////////////////////////////////////////////////////////////
	// states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_WBF = 3'h1;
	localparam [2:0] ST_CTX = 3'h2;
	localparam [2:0] ST_TLB = 3'h3;
	localparam [2:0] ST_EP_WAIT = 3'h4;
	localparam [2:0] ST_EP = 3'h5;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg wbf_ctx_ff; // wbf precedes context flush
	reg [4:0] ep_limit_ff;
	reg unknown_ff;

	wire [3:0] cmd_type;
	wire [1:0] cmd_level;
	wire take;
	wire is_ctx;
	wire is_tlb;
	wire is_ep;
	wire [15:0] raw_domain;
	wire [63:0] raw_addr;
	wire [5:0] rng_size;
	wire [63:0] rng_base;
	wire ep_may_issue;
	wire ep_issue;
	wire [63:0] dom_mask;
	wire [63:0] addr_mask;

	////////////////////////////////////////////////////////////////////////
	// helpers
	// ones in the low w bits, all ones for w of 64 or more
	function [63:0] low_mask;
		input integer w;
		begin
			low_mask = ~(64'hffff_ffff_ffff_ffff << w);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// field extraction
	// type from low nibble
	assign cmd_type = cmd_word[`IVD_TYPE_HI:`IVD_TYPE_LO];
	assign cmd_level = cmd_word[`IVD_LVL_HI:`IVD_LVL_LO];
	assign is_ctx = (cmd_type == `IVD_TYPE_CTX);
	assign is_tlb = (cmd_type == `IVD_TYPE_TLB);
	assign is_ep = (cmd_type == `IVD_TYPE_EP);
	assign raw_domain = cmd_word[`IVD_DOM_HI:`IVD_DOM_LO];
	assign raw_addr = cmd_word[`IVD_ADDR_HI:`IVD_ADDR_LO];
	assign dom_mask = low_mask(DOMAIN_W);
	assign addr_mask = low_mask(ADDR_W) & `IVD_PAGE_MASK;

	// handshake
	assign cmd_ready = (state_ff == ST_IDLE);
	assign take = cmd_valid && cmd_ready;
	assign busy = (state_ff != ST_IDLE);
	assign cmd_unknown = unknown_ff;

	////////////////////////////////////////////////////////////////////////
	// endpoint helpers
	ivd_range_decode u_range (
		.range_flag(cmd_word[`IVD_RANGE_BIT]),
		.addr_in(raw_addr),
		.size_log2(rng_size),
		.base_addr(rng_base)
	);

	assign ep_issue = ep_valid_ff && ep_ack;

	ivd_ep_throttle u_throttle (
		.ref_clk(ref_clk),
		.srst(srst),
		.throttle_en(throttle_en),
		.limit_hint(ep_limit_ff),
		.issue(ep_issue),
		.done(ep_done),
		.may_issue(ep_may_issue),
		.outstanding(ep_outstanding)
	);

	////////////////////////////////////////////////////////////////////////
	// next state
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take && (is_ctx || is_tlb)) begin
					if (write_buffer_flush_needed) begin
						nxt_state = ST_WBF;
					end else if (is_ctx) begin
						nxt_state = ST_CTX;
					end else begin
						nxt_state = ST_TLB;
					end
				end else if (take && is_ep) begin
					nxt_state = ST_EP_WAIT;
				end
			end
			ST_WBF: begin
				if (wbf_done) begin
					nxt_state = wbf_ctx_ff ? ST_CTX : ST_TLB;
				end
			end
			ST_CTX: begin
				if (ctx_ack) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_TLB: begin
				if (tlb_ack) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_EP_WAIT: begin
				if (ep_may_issue) begin
					nxt_state = ST_EP;
				end
			end
			ST_EP: begin
				if (ep_ack) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request strobes
	always @(posedge ref_clk) begin
		if (srst) begin
			wbf_req_ff <= 1'b0;
			ctx_valid_ff <= 1'b0;
			tlb_valid_ff <= 1'b0;
			ep_valid_ff <= 1'b0;
			unknown_ff <= 1'b0;
		end else begin
			wbf_req_ff <= (nxt_state == ST_WBF);
			ctx_valid_ff <= (nxt_state == ST_CTX);
			tlb_valid_ff <= (nxt_state == ST_TLB);
			ep_valid_ff <= (nxt_state == ST_EP);
			unknown_ff <= take && !is_ctx && !is_tlb && !is_ep;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// context flush fields
	always @(posedge ref_clk) begin
		if (srst) begin
			wbf_ctx_ff <= 1'b0;
			ctx_level_ff <= 2'h0;
			ctx_domain_ff <= 16'h0000;
			ctx_requester_ff <= 16'h0000;
			ctx_fmask_ff <= 2'h0;
		end else if (take && (is_ctx || is_tlb)) begin
			wbf_ctx_ff <= is_ctx;
		end
		if (!srst && take && is_ctx) begin
			ctx_level_ff <= (cmd_level == 2'h0) ? `IVD_CLVL_GLOBAL : cmd_level;
			ctx_domain_ff <= (cmd_level == `IVD_CLVL_DOMAIN || cmd_level == `IVD_CLVL_DEVICE)
				? raw_domain : 16'h0000;
			if (cmd_level == `IVD_CLVL_DEVICE) begin
				ctx_requester_ff <= cmd_word[`IVD_REQ_HI:`IVD_REQ_LO];
				ctx_fmask_ff <= cmd_word[`IVD_FMASK_HI:`IVD_FMASK_LO];
			end else begin
				ctx_requester_ff <= 16'h0000;
				ctx_fmask_ff <= 2'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// translation flush fields
	always @(posedge ref_clk) begin
		if (srst) begin
			tlb_level_ff <= 2'h0;
			tlb_domain_ff <= 16'h0000;
			tlb_addr_ff <= 64'h0000_0000_0000_0000;
			tlb_pmask_ff <= 6'h00;
			tlb_dir_flush_ff <= 1'b0;
		end else if (take && is_tlb) begin
			tlb_level_ff <= (cmd_level == 2'h0) ? `IVD_TLVL_GLOBAL : cmd_level;
			tlb_domain_ff <= (cmd_level == `IVD_TLVL_DOMAIN || cmd_level == `IVD_TLVL_PAGE)
				? (raw_domain & dom_mask[15:0]) : 16'h0000;
			if (cmd_level == `IVD_TLVL_PAGE) begin
				tlb_addr_ff <= raw_addr & addr_mask;
				tlb_pmask_ff <= cmd_word[`IVD_PMASK_HI:`IVD_PMASK_LO];
				tlb_dir_flush_ff <= !cmd_word[`IVD_HINT_BIT];
			end else begin
				tlb_addr_ff <= 64'h0000_0000_0000_0000;
				tlb_pmask_ff <= 6'h00;
				tlb_dir_flush_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// drain pending flags, set wins over clear
	always @(posedge ref_clk) begin
		if (srst) begin
			read_drain_ff <= 1'b0;
			write_drain_ff <= 1'b0;
		end else begin
			if (take && is_tlb && cmd_word[`IVD_RFLUSH_BIT]) begin
				read_drain_ff <= 1'b1;
			end else if (read_drain_done) begin
				read_drain_ff <= 1'b0;
			end
			if (take && is_tlb && cmd_word[`IVD_WFLUSH_BIT]) begin
				write_drain_ff <= 1'b1;
			end else if (write_drain_done) begin
				write_drain_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// endpoint flush fields
	always @(posedge ref_clk) begin
		if (srst) begin
			ep_requester_ff <= 16'h0000;
			ep_base_ff <= 64'h0000_0000_0000_0000;
			ep_size_ff <= 6'h00;
			ep_limit_ff <= 5'h00;
		end else if (take && is_ep) begin
			ep_requester_ff <= cmd_word[`IVD_REQ_HI:`IVD_REQ_LO];
			ep_base_ff <= rng_base;
			ep_size_ff <= rng_size;
			ep_limit_ff <= cmd_word[`IVD_OLIM_HI:`IVD_OLIM_LO];
		end
	end
endmodule // ivd_decoder

// ==== logic/ivd_ep_throttle.v ====
// outstanding endpoint invalidation counter and limiter
`timescale 1ns/1ps
`include "ivd_consts.vh"
module ivd_ep_throttle (
	input wire ref_clk, // clock
	input wire srst, // sync reset, high
	input wire throttle_en, // limiting enabled
	input wire [4:0] limit_hint, // outstanding limit hint
	input wire issue, // request sent
	input wire done, // request completed
	output wire may_issue, // room for another
	output wire [5:0] outstanding // current count
);
	reg [5:0] cnt_ff;
	reg [5:0] nxt_cnt;
	wire [5:0] limit;

	assign limit = (limit_hint == 5'h0_0) ? `IVD_EP_MAX_OUT : {1'b0, limit_hint};
	assign may_issue = (cnt_ff < `IVD_EP_MAX_OUT) && (!throttle_en || (cnt_ff < limit));
	assign outstanding = cnt_ff;

	// count issues minus completions
	always @* begin
		nxt_cnt = cnt_ff;
		if (issue && !done) begin
			nxt_cnt = cnt_ff + 6'h0_1;
		end else if (done && !issue && (cnt_ff != 6'h0_0)) begin
			nxt_cnt = cnt_ff - 6'h0_1;
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			cnt_ff <= 6'h0_0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule // ivd_ep_throttle

// ==== logic/ivd_range_decode.v ====
// endpoint flush size and base decode
`timescale 1ns/1ps
`include "ivd_consts.vh"
module ivd_range_decode (
	input wire range_flag, // range requested
	input wire [63:0] addr_in, // raw address
	output wire [5:0] size_log2, // log2 of bytes covered
	output wire [63:0] base_addr // aligned base
);
	// lowest zero bit at or above bit 12 sets the size
	function [5:0] range_log2;
		input [63:0] a;
		integer i;
		reg found;
		begin
			range_log2 = 6'h3f;
			found = 1'b0;
			for (i = `IVD_PAGE_LOG2; i < 63; i = i + 1) begin // stop at 63 so size saturates
				if (!found && !a[i]) begin
					range_log2 = i[5:0] + 6'h0_1;
					found = 1'b1;
				end
			end
		end
	endfunction

	assign size_log2 = range_flag ? range_log2(addr_in) : `IVD_PAGE_LOG2;
	assign base_addr = addr_in & ~((64'h0000_0000_0000_0001 << size_log2) - 64'h0000_0000_0000_0001);
endmodule // ivd_range_decode
